// >>> status_defs.svh
// Constants for the processor status register block
`ifndef STATUS_DEFS_SVH
`define STATUS_DEFS_SVH
`define PS_WIDTH 11
`define PS_BIT_C 0
`define PS_BIT_Z 1
`define PS_BIT_I 2
`define PS_BIT_D 3
`define PS_BIT_X 4
`define PS_BIT_M 5
`define PS_BIT_V 6
`define PS_BIT_N 7
`define PS_LVL_LO 8
`define PS_LVL_HI 10
`define PS_RESET_VALUE 11'h004
`define SIGN16_BIT 15
`define SIGN8_BIT 7
`define BYTE_MASK 16'h00ff
`define ZERO16 16'h0000
`endif

// >>> status_pkg.sv
// Types shared by the processor status register block
package status_pkg;
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_ALU = 4'h1,
    OP_SET_CARRY = 4'h2,
    OP_CLEAR_CARRY = 4'h3,
    OP_SET_FLAG_BITS = 4'h4,
    OP_CLEAR_FLAG_BITS = 4'h5,
    OP_SET_IRQ_MASK = 4'h6,
    OP_CLEAR_IRQ_MASK = 4'h7,
    OP_SET_WIDTH_FLAG = 4'h8,
    OP_CLEAR_WIDTH_FLAG = 4'h9,
    OP_CLEAR_OVERFLOW = 4'ha,
    OP_POP_STATUS = 4'hb
  } status_op_t;

  // Result of an ALU step, with which flags it updates
  typedef struct packed {
    logic [15:0] result;
    logic carry;
    logic overflow;
    logic upd_carry;
    logic upd_zero;
    logic upd_overflow;
    logic upd_negative;
    logic decimal_add;
  } alu_flags_t;

  typedef enum logic [1:0] {
    IRQ_IDLE = 2'b00,
    IRQ_ACCEPT = 2'b01,
    IRQ_HOLD = 2'b11
  } irq_state_t;
endpackage

// >>> flag_cell.sv
// One status flag bit with set, clear, load and reset value
`include "status_defs.svh"
module flag_cell #(
  parameter logic RESET_VALUE = 1'b0
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic set_i,
  input wire logic clear_i,
  input wire logic load_i,
  input wire logic load_value_i,
  output logic flag_o
);
  // Set wins over clear when both are asked in one cycle
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      flag_o <= RESET_VALUE;
    end else if (set_i) begin
      flag_o <= 1'b1;
    end else if (clear_i) begin
      flag_o <= 1'b0;
    end else if (load_i) begin
      flag_o <= load_value_i;
    end
  end
endmodule

// >>> priority_gate.sv
// Decides whether a requested interrupt may be accepted
module priority_gate (
  input wire logic request_i,
  input wire logic maskable_i,
  input wire logic [2:0] request_level_i,
  input wire logic [2:0] current_level_i,
  input wire logic irq_disable_i,
  output logic accept_o
);
  always_comb begin
    accept_o = request_i && (request_level_i > current_level_i) && !(maskable_i && irq_disable_i);
  end
endmodule

// >>> processor_status_flags.sv
// Processor status register: result flags, mode flags and priority level
// Summary of operation
// - Eleven-bit status register with flags and level
// - Branches test only carry, zero, overflow, negative
// - Bit 0 takes ALU carry, shifts, rotates
// - Carry set/cleared by dedicated and generic ops
// - Bit 1 marks zero result; generic ops change
// - Zero after decimal add is undefined
// - Bit 2 blocks only maskable interrupts
// - Accepting interrupt sets disable; ops change it
// - Reset sets interrupt disable flag
// - Reset clears decimal, index, data width flags
// - Bit 3 selects decimal add/subtract mode
// - Bit 4 selects 8-bit index registers
// - Bit 5 selects 8-bit data width
// - Bit 6 flags signed overflow per width
// - Overflow set/cleared by ops; decimal undefined
// - Bit 7 copies result sign bit
// - Bits 8-10 hold priority level 0-7
// - Accept only strictly higher requested level
// - Acceptance saves level, loads accepted level
// - Level changes only by acceptance or status pop
`include "status_defs.svh"
module processor_status_flags
  import status_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire status_op_t op_i,
  input wire logic [7:0] flag_mask_i,
  input wire logic [10:0] pop_value_i,
  input wire alu_flags_t alu_i,
  input wire logic irq_request_i,
  input wire logic irq_maskable_i,
  input wire logic [2:0] irq_level_i,
  input wire logic [3:0] branch_cond_i,
  output logic [10:0] processor_status_o,
  output logic irq_accept_o,
  output logic [2:0] saved_level_o,
  output logic branch_taken_o,
  output logic index_8bit_o,
  output logic data_8bit_o,
  output logic decimal_mode_o
);
  // ----------------------------------------------------------------
  // Flag storage
  // ----------------------------------------------------------------
  logic [7:0] flag_q;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic [7:0] load_vec;
  logic [7:0] load_val;
  logic [2:0] processor_priority_level_reg;
  logic accept;
  logic [15:0] res_w;
  logic sign_w;
  logic zero_w;
  irq_state_t irq_state_reg;
  irq_state_t irq_state_next;

  // Reset values of each flag: disable set, modes clear
  localparam logic [7:0] FLAG_RESET = 8'(`PS_RESET_VALUE);

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_flag
      flag_cell #(
        .RESET_VALUE(FLAG_RESET[g])
      ) u_flag (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .set_i(set_vec[g]),
        .clear_i(clr_vec[g]),
        .load_i(load_vec[g]),
        .load_value_i(load_val[g]),
        .flag_o(flag_q[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // ALU result evaluation
  // ----------------------------------------------------------------
  always_comb begin
    res_w = flag_q[`PS_BIT_M] ? (alu_i.result & `BYTE_MASK) : alu_i.result;
    sign_w = flag_q[`PS_BIT_M] ? alu_i.result[`SIGN8_BIT] : alu_i.result[`SIGN16_BIT];
    zero_w = (res_w == `ZERO16);
  end

  // ----------------------------------------------------------------
  // Per-bit set, clear and load requests
  // ----------------------------------------------------------------
  always_comb begin
    set_vec = 8'h00;
    clr_vec = 8'h00;
    load_vec = 8'h00;
    load_val = 8'h00;
    case (op_i)
      OP_ALU: begin
        load_vec[`PS_BIT_C] = alu_i.upd_carry;
        load_val[`PS_BIT_C] = alu_i.carry;
        // Zero after a decimal add is left as computed; nobody may rely on it
        load_vec[`PS_BIT_Z] = alu_i.upd_zero;
        load_val[`PS_BIT_Z] = zero_w;
        // Caller computes overflow at the width set by bit 5
        load_vec[`PS_BIT_V] = alu_i.upd_overflow;
        load_val[`PS_BIT_V] = alu_i.overflow;
        load_vec[`PS_BIT_N] = alu_i.upd_negative;
        load_val[`PS_BIT_N] = sign_w;
      end
      OP_SET_CARRY: set_vec[`PS_BIT_C] = 1'b1;
      OP_CLEAR_CARRY: clr_vec[`PS_BIT_C] = 1'b1;
      OP_SET_FLAG_BITS: set_vec = flag_mask_i;
      OP_CLEAR_FLAG_BITS: clr_vec = flag_mask_i;
      OP_SET_IRQ_MASK: set_vec[`PS_BIT_I] = 1'b1;
      OP_CLEAR_IRQ_MASK: clr_vec[`PS_BIT_I] = 1'b1;
      OP_SET_WIDTH_FLAG: set_vec[`PS_BIT_M] = 1'b1;
      OP_CLEAR_WIDTH_FLAG: clr_vec[`PS_BIT_M] = 1'b1;
      OP_CLEAR_OVERFLOW: clr_vec[`PS_BIT_V] = 1'b1;
      OP_POP_STATUS: begin
        load_vec = 8'hff;
        load_val = pop_value_i[`PS_BIT_N:`PS_BIT_C];
      end
      default: begin
        set_vec = 8'h00;
      end
    endcase
    // Acceptance outranks any op on the disable flag
    if (accept) begin
      set_vec[`PS_BIT_I] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt acceptance
  // ----------------------------------------------------------------
  priority_gate u_gate (
    .request_i(irq_request_i && (irq_state_reg == IRQ_IDLE)),
    .maskable_i(irq_maskable_i),
    .request_level_i(irq_level_i),
    .current_level_i(processor_priority_level_reg),
    .irq_disable_i(flag_q[`PS_BIT_I]),
    .accept_o(accept)
  );

  // One acceptance per request; the request must drop before the next
  always_comb begin
    case (irq_state_reg)
      IRQ_IDLE: irq_state_next = accept ? IRQ_ACCEPT : IRQ_IDLE;
      IRQ_ACCEPT: irq_state_next = IRQ_HOLD;
      IRQ_HOLD: irq_state_next = irq_request_i ? IRQ_HOLD : IRQ_IDLE;
      default: irq_state_next = IRQ_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      irq_state_reg <= IRQ_IDLE;
    end else begin
      irq_state_reg <= irq_state_next;
    end
  end

  // ----------------------------------------------------------------
  // Priority level field
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      processor_priority_level_reg <= 3'(`PS_RESET_VALUE >> `PS_LVL_LO);
    end else if (accept) begin
      processor_priority_level_reg <= irq_level_i;
    end else if (op_i == OP_POP_STATUS) begin
      processor_priority_level_reg <= pop_value_i[`PS_LVL_HI:`PS_LVL_LO];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      irq_accept_o <= 1'b0;
      saved_level_o <= 3'h0;
    end else begin
      irq_accept_o <= accept;
      if (accept) begin
        saved_level_o <= processor_priority_level_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Branch evaluation and registered outputs
  // ----------------------------------------------------------------
  // Condition code: [3:2] selects C, Z, V or N, [0] the wanted value
  logic branch_flag;
  always_comb begin
    case (branch_cond_i[3:2])
      2'b00: branch_flag = flag_q[`PS_BIT_C];
      2'b01: branch_flag = flag_q[`PS_BIT_Z];
      2'b10: branch_flag = flag_q[`PS_BIT_V];
      default: branch_flag = flag_q[`PS_BIT_N];
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      branch_taken_o <= 1'b0;
    end else begin
      branch_taken_o <= (branch_flag == branch_cond_i[0]);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      processor_status_o <= `PS_RESET_VALUE;
      index_8bit_o <= 1'b0;
      data_8bit_o <= 1'b0;
      decimal_mode_o <= 1'b0;
    end else begin
      processor_status_o <= {processor_priority_level_reg, flag_q};
      index_8bit_o <= flag_q[`PS_BIT_X];
      data_8bit_o <= flag_q[`PS_BIT_M];
      decimal_mode_o <= flag_q[`PS_BIT_D];
    end
  end
endmodule

// >>> status_checker_assertions.sv
// Checker for the processor status register block
module status_checker
  import status_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire status_op_t op_i,
  input wire logic [7:0] flag_mask_i,
  input wire logic [10:0] pop_value_i,
  input wire alu_flags_t alu_i,
  input wire logic irq_request_i,
  input wire logic irq_maskable_i,
  input wire logic [2:0] irq_level_i,
  input wire logic [10:0] processor_status_o,
  input wire logic irq_accept_o,
  input wire logic [2:0] saved_level_o
);
  // ----------
  // Properties
  // ----------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  wire logic [10:0] st = processor_status_o;
  chk_reset_value:
    assert property (disable iff (1'b0) !reset_n_i |=> st == 11'h004) else $error("bad reset value");
  chk_set_carry:
    assert property (op_i == OP_SET_CARRY |-> ##2 st[0]) else $error("carry not set");
  chk_clear_mask:
    assert property (op_i == OP_CLEAR_FLAG_BITS && !irq_request_i |-> ##2 (st[7:0] & $past(flag_mask_i, 2)) == 8'h00)
    else $error("masked bits not cleared");
  chk_pop_loads:
    assert property (op_i == OP_POP_STATUS && !irq_request_i |-> ##2 st == $past(pop_value_i, 2))
    else $error("pop value not loaded");
  chk_zero_flag:
    assert property (op_i == OP_ALU && alu_i.upd_zero && !alu_i.decimal_add |-> ##2
      st[1] == (st[5] ? $past(alu_i.result[7:0], 2) == 8'h00 : $past(alu_i.result, 2) == 16'h0000))
    else $error("zero flag wrong");
  chk_negative_flag:
    assert property (op_i == OP_ALU && alu_i.upd_negative && !alu_i.decimal_add |-> ##2
      st[7] == (st[5] ? $past(alu_i.result[7], 2) : $past(alu_i.result[15], 2)))
    else $error("negative flag wrong");
  chk_accept_level:
    assert property (irq_accept_o |-> $past(irq_level_i) > st[10:8] && saved_level_o == st[10:8])
    else $error("accept at wrong level");
  chk_mask_gate:
    assert property (irq_accept_o |-> !$past(irq_maskable_i) || !st[2]) else $error("masked request taken");
  chk_accept_load:
    assert property (irq_accept_o |=> st[2] && st[10:8] == $past(irq_level_i, 2))
    else $error("accept did not load level");
  chk_level_source:
    assert property ($changed(st[10:8]) |-> $past(irq_accept_o) || $past(op_i, 2) == OP_POP_STATUS)
    else $error("level changed without cause");
  cover property (irq_accept_o);
  cover property (op_i == OP_POP_STATUS);
  cover property (op_i == OP_ALU && alu_i.upd_zero);
endmodule
bind processor_status_flags status_checker i_chk (.mclk_i, .reset_n_i, .op_i, .flag_mask_i, .pop_value_i,
  .alu_i, .irq_request_i, .irq_maskable_i, .irq_level_i, .processor_status_o, .irq_accept_o, .saved_level_o);

// >>> test_processor_status_flags.sv
// Self-checking bench for the processor status register block
module test_processor_status_flags
  import status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // -----
  // Setup
  // -----
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  status_op_t op_i = OP_NONE;
  logic [7:0] flag_mask_i = 8'h00;
  logic [10:0] pop_value_i = 11'h000;
  alu_flags_t alu_i = '0;
  logic irq_request_i = 1'b0;
  logic irq_maskable_i = 1'b0;
  logic [2:0] irq_level_i = 3'h0;
  logic [3:0] branch_cond_i = 4'h0;
  logic [10:0] processor_status_o;
  logic [2:0] saved_level_o;
  logic irq_accept_o, branch_taken_o, index_8bit_o, data_8bit_o, decimal_mode_o;
  int fails = 0;
  int n_compared = 0;
  logic [31:0] r = 32'h2af1_dc47;
  always #10 mclk_i = ~mclk_i;
  processor_status_flags i_dut (.mclk_i, .reset_n_i, .op_i, .flag_mask_i, .pop_value_i, .alu_i,
    .irq_request_i, .irq_maskable_i, .irq_level_i, .branch_cond_i, .processor_status_o, .irq_accept_o,
    .saved_level_o, .branch_taken_o, .index_8bit_o, .data_8bit_o, .decimal_mode_o);
  task automatic compare(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("compared=%0d fails=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [10:0] nxt(input logic [10:0] p, input status_op_t op, input logic [7:0] mk,
                                      input logic [10:0] pv, input alu_flags_t a);
    logic [10:0] n;
    n = p;
    case (op)
      OP_ALU: begin
        if (a.upd_carry) n[0] = a.carry;
        if (a.upd_zero) n[1] = p[5] ? a.result[7:0] == 8'h00 : a.result == 16'h0000;
        if (a.upd_overflow) n[6] = a.overflow;
        if (a.upd_negative) n[7] = p[5] ? a.result[7] : a.result[15];
      end
      OP_SET_CARRY: n[0] = 1'b1;
      OP_CLEAR_CARRY: n[0] = 1'b0;
      OP_SET_FLAG_BITS: n[7:0] = p[7:0] | mk;
      OP_CLEAR_FLAG_BITS: n[7:0] = p[7:0] & ~mk;
      OP_SET_IRQ_MASK: n[2] = 1'b1;
      OP_CLEAR_IRQ_MASK: n[2] = 1'b0;
      OP_SET_WIDTH_FLAG: n[5] = 1'b1;
      OP_CLEAR_WIDTH_FLAG: n[5] = 1'b0;
      OP_CLEAR_OVERFLOW: n[6] = 1'b0;
      OP_POP_STATUS: n = pv;
      default: ;
    endcase
    return n;
  endfunction
  function automatic logic br(input logic [3:0] c, input logic [10:0] p);
    logic [3:0] f;
    f = {p[7], p[6], p[1], p[0]};
    return f[c[3:2]] == c[0];
  endfunction
  // -----
  // Tests
  // -----
  initial begin
    logic [10:0] m;
    logic [10:0] mq[$];
    logic [3:0] cq[$];
    status_op_t op;
    alu_flags_t a;
    logic [2:0] cur;
    logic ok;
    repeat (4) @(posedge mclk_i);
    compare(processor_status_o, 11'h004);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    m = 11'h004;
    mq = '{m, m, m};
    cq = '{4'h0, 4'h0};
    // Random ops with no requests, so the model needs no interrupt path
    repeat (600) begin
      @(posedge mclk_i);
      compare(processor_status_o, mq[0]);
      compare(branch_taken_o, br(cq[0], mq[0]));
      compare({decimal_mode_o, index_8bit_o, data_8bit_o}, {mq[0][3], mq[0][4], mq[0][5]});
      void'(mq.pop_front());
      void'(cq.pop_front());
      r = lfsr(lfsr(r));
      op = status_op_t'(4'(r[31:28] % 4'd12));
      a = r[22:0];
      a.decimal_add = 1'b0;
      op_i <= op;
      alu_i <= a;
      flag_mask_i <= r[23:16];
      pop_value_i <= r[26:16];
      branch_cond_i <= r[27:24];
      m = nxt(m, op, r[23:16], r[26:16], a);
      mq.push_back(m);
      cq.push_back(r[27:24]);
    end
    op_i <= OP_SET_FLAG_BITS;
    flag_mask_i <= 8'hff;
    @(posedge mclk_i);
    op_i <= OP_NONE;
    reset_n_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    compare(processor_status_o, 11'h004);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    repeat (40) begin
      r = lfsr(r);
      cur = r[2:0];
      op_i <= OP_POP_STATUS;
      pop_value_i <= {cur, r[15:8]};
      @(posedge mclk_i);
      op_i <= OP_NONE;
      @(posedge mclk_i);
      irq_request_i <= 1'b1;
      irq_level_i <= r[18:16];
      irq_maskable_i <= r[19];
      ok = r[18:16] > cur && (!r[19] || !r[10]);
      @(posedge mclk_i);
      irq_request_i <= 1'b0;
      @(posedge mclk_i);
      compare(irq_accept_o, ok);
      if (ok) compare(saved_level_o, cur);
      @(posedge mclk_i);
      compare(processor_status_o[10:8], ok ? r[18:16] : cur);
      compare(processor_status_o[2], ok | r[10]);
    end
    summarize();
  end
  // Hang guard, well past the expected run of about 815 cycles
  initial begin
    repeat (5000) @(posedge mclk_i);
    fails++;
    summarize();
  end
endmodule
